// [rtl/cmo_msg_ctrl.sv]
// Overview of operation
// - data frame receive with rx enable sets pending flag
// - transmit with tx enable sets pending flag
// - last object transmit bits stuck inactive
// - receive store rewrites unused data bytes
// - fresh during send keeps send request
// - request on receive object sends remote
// - send success clears request and remote pending
// - lowest numbered pending object goes first
// - identifier used for filter and send
// - 29-bit identifier, standard uses 28..18
// - standard objects ignore bits 17..0
// - two-bit pairs: 01 clear, 10 set
// - objects on 16-index stride, control first
`timescale 1ns/1ps
module cmo_msg_ctrl import cmo_pkg::*; #(
	parameter int NOBJ = 15,
	parameter int AW = 12
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// interrupt
	output logic irq,
	// frames from the protocol core
	input wire logic rx_valid,
	input wire logic [28:0] rx_id,
	input wire logic rx_ide,
	input wire logic rx_rtr,
	input wire logic [3:0] rx_dlc,
	// strobe to the data byte store
	output logic rx_store,
	output logic [3:0] rx_store_obj,
	output logic [3:0] rx_store_dlc,
	// transmit request to the protocol core
	output logic tx_req,
	output logic [3:0] tx_obj,
	output logic [28:0] tx_id,
	output logic tx_ide,
	output logic tx_rtr,
	input wire logic tx_done,
	input wire logic tx_abort
);
	// ==========================================================
	// elaboration checks
	if (NOBJ < 1 || NOBJ > 15) begin : g_bad_nobj
		$error("NOBJ must lie in 1..15");
	end
	if (AW < 10) begin : g_bad_aw
		$error("AW too small for the object map");
	end

	// ==========================================================
	// state
	typedef enum logic [1:0] {
		S_IDLE = 2'b01,
		S_SEND = 2'b10
	} cmo_fsm_t;

	typedef struct packed {
		cmo_fsm_t fsm;
		logic [NOBJ:1] irq_pending;
		logic [NOBJ:1] rx_irq_enable;
		logic [NOBJ:1] tx_irq_enable;
		logic [NOBJ:1] valid;
		logic [NOBJ:1] fresh;
		logic [NOBJ:1] lostupd;
		logic [NOBJ:1] sendrq;
		logic [NOBJ:1] remote_pending;
		logic [NOBJ:1] dir;
		logic [NOBJ:1] xtd;
		logic [NOBJ:1][ID_W-1:0] id;
		logic [EV_W-1:0] irq_st;
		logic [EV_W-1:0] irq_en;
		logic irq;
		logic pready;
		logic slverr;
		logic [31:0] prdata;
		logic rx_store;
		logic [3:0] rx_store_obj;
		logic [3:0] rx_store_dlc;
		logic tx_req;
		logic [3:0] tx_obj;
		logic [ID_W-1:0] tx_id;
		logic tx_ide;
		logic tx_rtr;
	} cmo_st_t;

	cmo_st_t st_q;
	cmo_st_t st_d;

	cmo_sel_if #(.NOBJ(NOBJ)) sel_bus ();

	cmo_select #(.NOBJ(NOBJ)) u_select (
		.s(sel_bus.sel)
	);

	// ==========================================================
	// candidate masks for the selector
	always_comb begin
		sel_bus.tx_cand = st_q.valid & st_q.sendrq & ~(st_q.dir & st_q.lostupd);
		sel_bus.rx_cand = st_q.valid & (rx_rtr ? st_q.dir : ~st_q.dir);
		sel_bus.xtd = st_q.xtd;
		sel_bus.id = st_q.id;
		sel_bus.rx_id = rx_id;
		sel_bus.rx_ide = rx_ide;
	end

	// ==========================================================
	// next state
	logic [3:0] a_obj;
	logic [3:0] a_sub;
	logic a_ok;
	logic acc;
	logic wr;
	logic [3:0] k;
	logic [3:0] t;
	logic [EV_W-1:0] ev;
	logic [EV_W-1:0] clr;

	always_comb begin
		st_d = st_q;
		ev = '0;
		clr = '0;
		k = sel_bus.rx_idx;
		t = st_q.tx_obj;
		st_d.pready = 1'b0;
		st_d.slverr = 1'b0;
		st_d.rx_store = 1'b0;

		// address decode: byte address is four times the index
		a_obj = paddr[9:6];
		a_sub = paddr[5:2];
		acc = psel && penable;
		if (paddr[AW-1:10] != '0 || 32'(a_obj) > NOBJ)
			a_ok = 1'b0;
		else if (a_obj == 4'h0)
			a_ok = (a_sub == IDX_IRQ_STAT) || (a_sub == IDX_IRQ_EN) || (a_sub == IDX_IRQ_CLR);
		else
			a_ok = (a_sub == IDX_CTL) || (a_sub == IDX_ARBH) || (a_sub == IDX_ARBL)
				|| (a_sub == IDX_CFG);
		wr = acc && st_q.pready && pwrite && !st_q.slverr;

		// ==========================================================
		// apb: one wait state, read data captured with pready
		if (acc && !st_q.pready) begin
			st_d.pready = 1'b1;
			st_d.slverr = !a_ok;
			st_d.prdata = RESET_WORD;
			if (a_ok && !pwrite) begin
				if (a_obj == 4'h0) begin
					unique case (a_sub)
						IDX_IRQ_STAT: st_d.prdata = 32'(st_q.irq_st);
						IDX_IRQ_EN: st_d.prdata = 32'(st_q.irq_en);
						default: st_d.prdata = RESET_WORD;
					endcase
				end else begin
					unique case (a_sub)
						IDX_CTL: st_d.prdata = {16'h0000, pair_rd(st_q.remote_pending[a_obj]),
							pair_rd(st_q.sendrq[a_obj]), pair_rd(st_q.lostupd[a_obj]),
							pair_rd(st_q.fresh[a_obj]), pair_rd(st_q.valid[a_obj]),
							pair_rd(st_q.tx_irq_enable[a_obj]), pair_rd(st_q.rx_irq_enable[a_obj]),
							pair_rd(st_q.irq_pending[a_obj])};
						IDX_ARBH: st_d.prdata = {16'h0000, st_q.id[a_obj][20:13],
							st_q.id[a_obj][28:21]};
						IDX_ARBL: st_d.prdata = {16'h0000, st_q.id[a_obj][4:0], 3'h0,
							st_q.id[a_obj][12:5]};
						IDX_CFG: st_d.prdata = {30'h0000_0000, st_q.xtd[a_obj], st_q.dir[a_obj]};
						default: st_d.prdata = RESET_WORD;
					endcase
				end
			end
		end

		// ==========================================================
		// software writes, taken at the pready edge
		if (wr) begin
			if (a_obj == 4'h0) begin
				if (a_sub == IDX_IRQ_EN)
					st_d.irq_en = pwdata[EV_W-1:0];
				if (a_sub == IDX_IRQ_CLR)
					clr = pwdata[EV_W-1:0];
			end else begin
				unique case (a_sub)
					IDX_CTL: begin
						st_d.irq_pending[a_obj] = pair_wr(st_q.irq_pending[a_obj], pwdata[P_IRQ_PENDING+:2]);
						st_d.rx_irq_enable[a_obj] = pair_wr(st_q.rx_irq_enable[a_obj], pwdata[P_RX_IRQ_ENABLE+:2]);
						st_d.tx_irq_enable[a_obj] = pair_wr(st_q.tx_irq_enable[a_obj], pwdata[P_TX_IRQ_ENABLE+:2]);
						st_d.valid[a_obj] = pair_wr(st_q.valid[a_obj], pwdata[P_VALID+:2]);
						st_d.fresh[a_obj] = pair_wr(st_q.fresh[a_obj], pwdata[P_FRESH+:2]);
						st_d.lostupd[a_obj] = pair_wr(st_q.lostupd[a_obj], pwdata[P_LOSTUPD+:2]);
						st_d.sendrq[a_obj] = pair_wr(st_q.sendrq[a_obj], pwdata[P_SENDRQ+:2]);
						st_d.remote_pending[a_obj] = pair_wr(st_q.remote_pending[a_obj], pwdata[P_REMOTE_PENDING+:2]);
					end
					IDX_ARBH: begin
						st_d.id[a_obj][20:13] = pwdata[15:8];
						st_d.id[a_obj][28:21] = pwdata[7:0];
					end
					IDX_ARBL: begin
						st_d.id[a_obj][4:0] = pwdata[15:11];
						st_d.id[a_obj][12:5] = pwdata[7:0];
					end
					IDX_CFG: begin
						st_d.dir[a_obj] = pwdata[CFG_DIR];
						st_d.xtd[a_obj] = pwdata[CFG_XTD];
					end
					default: st_d.dir = st_d.dir;
				endcase
			end
		end

		// ==========================================================
		// transmit sequencing; hardware clears follow software writes
		unique case (st_q.fsm)
			S_IDLE: begin
				if (sel_bus.tx_hit) begin
					t = sel_bus.tx_idx;
					st_d.fsm = S_SEND;
					st_d.tx_req = 1'b1;
					st_d.tx_obj = t;
					st_d.tx_ide = st_q.xtd[t];
					st_d.tx_id = st_q.xtd[t] ? st_q.id[t] : {st_q.id[t][ID_W-1:STD_LSB], 18'h00000};
					st_d.tx_rtr = !st_q.dir[t];
					// taking a snapshot: a later fresh mark means newer data
					if (st_q.dir[t] && !(wr && a_obj == t && a_sub == IDX_CTL
							&& pwdata[P_FRESH+:2] == PAIR_SET))
						st_d.fresh[t] = 1'b0;
				end
			end
			S_SEND: begin
				if (tx_done) begin
					st_d.fsm = S_IDLE;
					st_d.tx_req = 1'b0;
					ev[EV_TX] = 1'b1;
					if (!st_d.fresh[t]) begin
						st_d.sendrq[t] = 1'b0;
						st_d.remote_pending[t] = 1'b0;
					end
					if (st_q.tx_irq_enable[t])
						st_d.irq_pending[t] = 1'b1;
				end else if (tx_abort) begin
					// lost arbitration or error: request stays, retried later
					st_d.fsm = S_IDLE;
					st_d.tx_req = 1'b0;
				end
			end
		endcase

		// ==========================================================
		// receive; hardware sets win over same-cycle software clears
		if (rx_valid && sel_bus.rx_hit) begin
			if (rx_rtr) begin
				st_d.sendrq[k] = 1'b1;
				st_d.remote_pending[k] = 1'b1;
			end else begin
				st_d.rx_store = 1'b1;
				st_d.rx_store_obj = k;
				st_d.rx_store_dlc = rx_dlc;
				ev[EV_RX] = 1'b1;
				if (st_q.fresh[k]) begin
					st_d.lostupd[k] = 1'b1;
					ev[EV_LOST] = 1'b1;
				end
				st_d.fresh[k] = 1'b1;
				if (st_q.rx_irq_enable[k])
					st_d.irq_pending[k] = 1'b1;
			end
		end

		// last object can never be sent
		st_d.tx_irq_enable[NOBJ] = 1'b0;
		st_d.sendrq[NOBJ] = 1'b0;

		// ==========================================================
		// interrupt: sticky status, write-one clear, event wins
		st_d.irq_st = (st_q.irq_st & ~clr) | ev;
		st_d.irq = |(st_d.irq_st & st_d.irq_en);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			st_q <= '0;
			st_q.fsm <= S_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// ==========================================================
	// outputs
	assign prdata = st_q.prdata;
	assign pready = st_q.pready;
	assign pslverr = st_q.slverr;
	assign irq = st_q.irq;
	assign rx_store = st_q.rx_store;
	assign rx_store_obj = st_q.rx_store_obj;
	assign rx_store_dlc = st_q.rx_store_dlc;
	assign tx_req = st_q.tx_req;
	assign tx_obj = st_q.tx_obj;
	assign tx_id = st_q.tx_id;
	assign tx_ide = st_q.tx_ide;
	assign tx_rtr = st_q.tx_rtr;
endmodule // cmo_msg_ctrl

// [rtl/cmo_pkg.sv]
package cmo_pkg;
	// ==========================================================
	// register map (printed offsets are word indices)
	localparam int OBJ_STRIDE = 16;
	localparam logic [3:0] IDX_CTL = 4'h0;
	localparam logic [3:0] IDX_ARBH = 4'h2;
	localparam logic [3:0] IDX_ARBL = 4'h4;
	localparam logic [3:0] IDX_CFG = 4'h6;
	localparam logic [3:0] IDX_IRQ_STAT = 4'h0;
	localparam logic [3:0] IDX_IRQ_EN = 4'h1;
	localparam logic [3:0] IDX_IRQ_CLR = 4'h2;

	// ==========================================================
	// control pair positions
	localparam int P_IRQ_PENDING = 0;
	localparam int P_RX_IRQ_ENABLE = 2;
	localparam int P_TX_IRQ_ENABLE = 4;
	localparam int P_VALID = 6;
	localparam int P_FRESH = 8;
	localparam int P_LOSTUPD = 10;
	localparam int P_SENDRQ = 12;
	localparam int P_REMOTE_PENDING = 14;
	localparam logic [1:0] PAIR_SET = 2'h2;
	localparam logic [1:0] PAIR_CLR = 2'h1;

	// ==========================================================
	// config register bits and event bits
	localparam int CFG_DIR = 0;
	localparam int CFG_XTD = 1;
	localparam int EV_RX = 0;
	localparam int EV_TX = 1;
	localparam int EV_LOST = 2;
	localparam int EV_W = 3;

	// ==========================================================
	// identifier layout
	localparam int ID_W = 29;
	localparam int STD_LSB = 18;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	// two-bit complementary write: 01 clears, 10 sets, 11 and 00 keep
	function automatic logic pair_wr(input logic old, input logic [1:0] v);
		unique case (v)
			PAIR_SET: pair_wr = 1'b1;
			PAIR_CLR: pair_wr = 1'b0;
			default: pair_wr = old;
		endcase
	endfunction

	function automatic logic [1:0] pair_rd(input logic b);
		pair_rd = b ? PAIR_SET : PAIR_CLR;
	endfunction

	// standard ids compare only bits 28..18
	function automatic logic id_match(input logic [ID_W-1:0] a, input logic a_xtd,
			input logic [ID_W-1:0] b, input logic b_xtd);
		if (a_xtd != b_xtd)
			id_match = 1'b0;
		else if (a_xtd)
			id_match = (a == b);
		else
			id_match = (a[ID_W-1:STD_LSB] == b[ID_W-1:STD_LSB]);
	endfunction

	// lowest set index, bit 0 never used
	function automatic logic [3:0] lowest_idx(input logic [15:0] m);
		lowest_idx = 4'h0;
		for (int i = 15; i >= 1; i--) begin
			if (m[i])
				lowest_idx = 4'(i);
		end
	endfunction
endpackage

// [rtl/cmo_sel_if.sv]
`timescale 1ns/1ps
interface cmo_sel_if #(parameter int NOBJ = 15);
	logic [NOBJ:1] tx_cand;
	logic [NOBJ:1] rx_cand;
	logic [NOBJ:1] xtd;
	logic [NOBJ:1][28:0] id;
	logic [28:0] rx_id;
	logic rx_ide;
	logic tx_hit;
	logic rx_hit;
	logic [3:0] tx_idx;
	logic [3:0] rx_idx;
	modport ctrl (output tx_cand, rx_cand, xtd, id, rx_id, rx_ide,
		input tx_hit, rx_hit, tx_idx, rx_idx);
	modport sel (input tx_cand, rx_cand, xtd, id, rx_id, rx_ide,
		output tx_hit, rx_hit, tx_idx, rx_idx);
endinterface

// [rtl/cmo_select.sv]
`timescale 1ns/1ps
module cmo_select import cmo_pkg::*; #(
	parameter int NOBJ = 15
) (
	cmo_sel_if.sel s
);
	// ==========================================================
	// acceptance and priority
	logic [15:0] tx_m;
	logic [15:0] rx_m;

	always_comb begin
		tx_m = 16'h0000;
		rx_m = 16'h0000;
		for (int k = 1; k <= NOBJ; k++) begin
			tx_m[k] = s.tx_cand[k];
			rx_m[k] = s.rx_cand[k] && id_match(s.id[k], s.xtd[k], s.rx_id, s.rx_ide);
		end
		s.tx_hit = |tx_m;
		s.rx_hit = |rx_m;
		s.tx_idx = lowest_idx(tx_m);
		s.rx_idx = lowest_idx(rx_m);
	end
endmodule // cmo_select

// [testbench/cmo_msg_ctrl_monitor.sv]
`timescale 1ns/1ps
module cmo_mon (
	// ==========
	// watched ports
	input wire logic clock,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rx_valid,
	input wire logic rx_rtr,
	input wire logic [3:0] rx_dlc,
	input wire logic rx_store,
	input wire logic [3:0] rx_store_dlc,
	input wire logic tx_req,
	input wire logic [3:0] tx_obj,
	input wire logic [28:0] tx_id,
	input wire logic tx_ide,
	input wire logic tx_done,
	input wire logic tx_abort
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	chk_ready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("no ready after access");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	chk_tx_hold: assert property (tx_req && !tx_done && !tx_abort |=> tx_req && $stable(tx_id))
		else $error("request dropped or changed");
	chk_tx_end: assert property (tx_req && (tx_done || tx_abort) |=> !tx_req)
		else $error("request kept after end");
	chk_tx_obj: assert property (tx_req |-> tx_obj inside {[1:14]})
		else $error("bad send object");
	chk_std_tail: assert property (tx_req && !tx_ide |-> tx_id[17:0] == 18'h0)
		else $error("standard id tail not zero");
	chk_store_cause: assert property (rx_store |-> $past(rx_valid) && !$past(rx_rtr)
		&& rx_store_dlc == $past(rx_dlc))
		else $error("store without data frame");
endmodule // cmo_mon

bind cmo_msg_ctrl cmo_mon mon (.clock, .rst, .psel, .penable, .pready, .pslverr, .rx_valid,
	.rx_rtr, .rx_dlc, .rx_store, .rx_store_dlc, .tx_req, .tx_obj, .tx_id, .tx_ide, .tx_done,
	.tx_abort);

// [testbench/cmo_core_model.sv]
`timescale 1ns/1ps
module cmo_core_model (
	// ==========
	// clock, request, control
	input wire logic clock,
	input wire logic rst,
	input wire logic tx_req,
	input wire logic do_abort,
	input wire logic [3:0] lat,
	// answers
	output logic tx_done,
	output logic tx_abort
);
	logic [3:0] cnt_q;
	// slow answer leaves room for host writes mid-frame
	always_ff @(posedge clock) begin
		tx_done <= 1'b0;
		tx_abort <= 1'b0;
		if (rst || !tx_req || tx_done || tx_abort) begin
			cnt_q <= 4'h0;
		end else if (cnt_q == lat) begin
			tx_done <= !do_abort;
			tx_abort <= do_abort;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule // cmo_core_model

// [testbench/tb_can_message_object_control.sv]
`timescale 1ns/1ps
module tb_can_message_object_control import cmo_pkg::*;;
	logic clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
	logic rx_valid = 0, rx_ide = 0, rx_rtr = 0, do_abort = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, rd, prdata;
	logic [28:0] rx_id = 0, id3, id5, tx_id;
	logic [3:0] rx_dlc = 0, lat = 4'hF, rx_store_obj, rx_store_dlc, tx_obj;
	logic pready, pslverr, irq, rx_store, tx_req, tx_ide, tx_rtr, tx_done, tx_abort;
	int num_errors = 0, compares = 0;
	cmo_msg_ctrl uut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .irq, .rx_valid, .rx_id, .rx_ide, .rx_rtr, .rx_dlc, .rx_store, .rx_store_obj,
		.rx_store_dlc, .tx_req, .tx_obj, .tx_id, .tx_ide, .tx_rtr, .tx_done, .tx_abort);
	cmo_core_model core (.clock, .rst, .tx_req, .do_abort, .lat, .tx_done, .tx_abort);
	initial forever #2.5 clock = ~clock;
	// ==========
	// helpers
	function automatic logic [11:0] oa(input int n, input logic [3:0] i);
		oa = 12'(n * 64 + 4 * int'(i));
	endfunction
	function automatic logic [31:0] hi(input logic [28:0] id);
		hi = {16'h0, id[20:13], id[28:21]};
	endfunction
	function automatic logic [31:0] lo(input logic [28:0] id);
		lo = {16'h0, id[4:0], 3'h0, id[12:5]};
	endfunction
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		penable <= 1'b0;
		@(posedge clock);
		penable <= 1'b1;
		// request held until the edge that samples ready high
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge keeps back-to-back calls from driving psel twice at once
		@(posedge clock);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, rd, e);
	endtask
	task automatic wt(input logic v);
		int n;
		n = 0;
		while (tx_req !== v && n < 200) begin @(negedge clock); n++; end
		chk("tx_req", 32'(tx_req), 32'(v));
		@(posedge clock);
	endtask
	task automatic rxf(input logic [28:0] id, input logic ide, input logic e, input int ob);
		rx_id <= id; rx_ide <= ide; rx_rtr <= 1'b0; rx_dlc <= 4'($urandom_range(8));
		rx_valid <= 1'b1;
		@(posedge clock) rx_valid <= 1'b0;
		@(negedge clock) chk("rx_store", 32'(rx_store), 32'(e));
		if (e) chk("store_obj", 32'(rx_store_obj), 32'(ob));
		@(posedge clock);
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ==========
	// tests
	initial begin
		void'($urandom(88580));
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		rdc("ctl1", oa(1, IDX_CTL), 32'h5555);
		wr(oa(1, IDX_CTL), 32'hFFFF);
		wr(oa(1, IDX_CTL), 32'h0000);
		rdc("ctl1 keep", oa(1, IDX_CTL), 32'h5555);
		wr(oa(15, IDX_CTL), 32'hAAAA);
		rdc("ctl15", oa(15, IDX_CTL), 32'h9A9A);
		wr(oa(15, IDX_CTL), 32'h5555);
		rdc("unmapped", 12'h00C, 32'h0);
		chk("slverr", 32'(err), 32'h1);
		for (int n = 1; n < 15; n++) begin
			id5 = 29'($urandom);
			wr(oa(n, IDX_ARBH), hi(id5));
			wr(oa(n, IDX_ARBL), lo(id5) | 32'h700);
			rdc("arbh", oa(n, IDX_ARBH), hi(id5));
			rdc("arbl", oa(n, IDX_ARBL), lo(id5));
		end
		// invalid object 2 shares the id and must lose to 3
		id3 = 29'($urandom);
		for (int n = 2; n < 4; n++) begin
			wr(oa(n, IDX_ARBH), hi(id3));
			wr(oa(n, IDX_ARBL), lo(id3));
		end
		wr(oa(3, IDX_CTL), 32'hFFBB);
		wr(oa(0, IDX_IRQ_EN), 32'h7);
		rxf(id3, 1'b1, 1'b0, 0);
		rxf({id3[28:18], 18'($urandom)}, 1'b0, 1'b1, 3);
		rdc("ctl3", oa(3, IDX_CTL), 32'h569A);
		chk("irq", 32'(irq), 32'h1);
		rxf(id3, 1'b0, 1'b1, 3);
		rdc("ctl3 lost", oa(3, IDX_CTL), 32'h5A9A);
		rdc("status", oa(0, IDX_IRQ_STAT), 32'h5);
		wr(oa(0, IDX_IRQ_CLR), 32'h7);
		rdc("status clr", oa(0, IDX_IRQ_STAT), 32'h0);
		chk("irq clr", 32'(irq), 32'h0);
		id5 = 29'($urandom);
		wr(oa(5, IDX_ARBH), hi(id5));
		wr(oa(5, IDX_ARBL), lo(id5));
		for (int n = 5; n < 8; n += 2) begin
			wr(oa(n, IDX_CFG), 32'h3);
			wr(oa(n, IDX_CTL), 32'hFFAF);
		end
		do_abort <= 1'b1;
		wr(oa(7, IDX_CTL), 32'hEFFF);
		wt(1'b1);
		wr(oa(5, IDX_CTL), 32'hEFFF);
		wt(1'b0);
		do_abort <= 1'b0;
		wt(1'b1);
		chk("tx_obj", 32'(tx_obj), 32'h5);
		chk("tx_id", 32'(tx_id), 32'(id5));
		chk("tx_ctl", {tx_ide, tx_rtr}, 32'h2);
		wt(1'b0);
		rdc("ctl5", oa(5, IDX_CTL), 32'h55A6);
		rdc("status tx", oa(0, IDX_IRQ_STAT), 32'h2);
		wt(1'b1);
		wr(oa(7, IDX_CTL), 32'hF6FF);
		wt(1'b0);
		wt(1'b1);
		chk("resend", 32'(tx_obj), 32'h7);
		wr(oa(7, IDX_CTL), 32'hFF7F);
		wt(1'b0);
		// fresh cleared with the request, else the remote frame repeats forever
		wr(oa(3, IDX_CTL), 32'hEDFF);
		wt(1'b1);
		chk("remote", {tx_obj, tx_rtr, tx_ide}, 32'h0E);
		chk("remote id", 32'(tx_id), 32'({id3[28:18], 18'h0}));
		wt(1'b0);
		rdc("ctl3 sent", oa(3, IDX_CTL), 32'h599A);
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		complete_run();
	end
endmodule // tb_can_message_object_control
